// File: hw/gpio_buffer_pkg.sv
// Constants shared by the data-buffer and general-purpose port block.
// Assumes a single 40 MHz clock and a synchronous, active-high reset.
package gpio_buffer_pkg;

  // ==========================================================================
  // Register addresses
  // ==========================================================================
  localparam logic [15:0] FIXED_INPUT_PORT_ADDR = 16'h03f3;
  localparam logic [15:0] PORT_C_DATA_ADDR = 16'h15e8;
  localparam logic [15:0] SINGLE_BIT_PORT_ADDR = 16'h15e9;
  localparam logic [15:0] PORT_A_DATA_ADDR = 16'h15ea;
  localparam logic [15:0] PORT_B_DATA_ADDR = 16'h15eb;
  localparam logic [15:0] PORT_MODE_CONTROL_ADDR = 16'h15ec;
  localparam logic [15:0] PORT_C_BIT_MODIFIER_ADDR = 16'h15ed;

  // Low address bits under the port block select.
  localparam logic [2:0] SEL_PORT_C = 3'h0;
  localparam logic [2:0] SEL_PORT_Y = 3'h1;
  localparam logic [2:0] SEL_PORT_A = 3'h2;
  localparam logic [2:0] SEL_PORT_B = 3'h3;
  localparam logic [2:0] SEL_MODE = 3'h4;
  localparam logic [2:0] SEL_BIT_MOD = 3'h5;

  // ==========================================================================
  // Mode control fields
  // ==========================================================================
  localparam int MODE_HI_BIT = 7;
  localparam int MODE_LO_BIT = 6;
  localparam int STRENGTH_BIT = 5;
  localparam int TEST_BIT = 4;
  localparam int DIR_Y_BIT = 3;
  localparam int DIR_C_BIT = 2;
  localparam int DIR_B_BIT = 1;
  localparam int DIR_A_BIT = 0;
  localparam logic [7:0] MODE_CONTROL_RESET = 8'h00;
  localparam logic [7:0] PORT_DATA_RESET = 8'h00;

  typedef enum logic [1:0] {
    MODE_PLAIN,
    MODE_STROBE_A,
    MODE_STROBE_B,
    MODE_STROBE_BOTH
  } port_mode_e;

  // Handshake line positions inside a port C nibble.
  localparam int HS_STB = 0;
  localparam int HS_IBF = 1;
  localparam int HS_OBF = 2;
  localparam int HS_ACK = 3;
  localparam int BIT_VALUE_POS = 3;

  // ==========================================================================
  // DMA and timing
  // ==========================================================================
  localparam logic [2:0] DMA_NONE_CODE = 3'h4;
  localparam int SYNC_STAGES = 2;

endpackage

// File: hw/isa_data_buffer_io_ports.sv
// Data-buffer personality: bus steering, DMA request/acknowledge muxing,
// low-memory strobes and the general-purpose ports A, B, C, Y and Z.
// Assumes every pin input is asynchronous to clk_in and is therefore
// synchronised before use; bus strobes are slow compared with 25 ns.
`timescale 1ns/100ps
module isa_data_buffer_io_ports
  import gpio_buffer_pkg::*;
#(
  parameter int BUF_DEPTH = 2
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic [15:0] cpu_data_in,
  output logic [15:0] cpu_data_out,
  output logic [1:0] cpu_data_oe_n_out,
  input wire logic [15:0] sys_data_in,
  output logic [15:0] sys_data_out,
  output logic [1:0] sys_data_oe_n_out,
  input wire logic [15:0] ide_data_in,
  output logic [15:0] ide_data_out,
  output logic [1:0] ide_data_oe_n_out,
  input wire logic drive_low_byte_enable_n_in,
  input wire logic drive_high_byte_enable_n_in,
  input wire logic io_read_n_in,
  input wire logic io_write_n_in,
  input wire logic mem_read_n_in,
  input wire logic mem_write_n_in,
  input wire logic [2:0] addr_low_in,
  input wire logic port_block_select_n_in,
  input wire logic fixed_port_select_n_in,
  input wire logic [7:0] dma_request_in,
  input wire logic [2:0] channel_select_in,
  input wire logic ack_demux_enable_in,
  output logic merged_dma_request_out,
  output logic [7:0] dma_ack_n_out,
  input wire logic low_megabyte_flag_n_in,
  output logic low_mem_read_n_out,
  output logic low_mem_write_n_out,
  input wire logic [7:0] port_a_in,
  output logic [7:0] port_a_out,
  output logic [7:0] port_a_oe_n_out,
  input wire logic [7:0] port_b_in,
  output logic [7:0] port_b_out,
  output logic [7:0] port_b_oe_n_out,
  input wire logic [7:0] port_c_in,
  output logic [7:0] port_c_out,
  output logic [7:0] port_c_oe_n_out,
  input wire logic port_y_in,
  output logic port_y_out,
  output logic port_y_oe_n_out,
  input wire logic [3:0] port_z_in,
  output logic full_strength_out
);

  localparam int ASYNC_W = 101;
  localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam int CNT_W = $clog2(BUF_DEPTH + 1);

  function automatic logic [PTR_W-1:0] next_ptr(input logic [PTR_W-1:0] ptr);
    next_ptr = (32'(ptr) == BUF_DEPTH - 1) ? '0 : ptr + 1'b1;
  endfunction

  // Port C lines that belong to a strobed port's handshake.
  function automatic logic [7:0] hs_mask(input port_mode_e m);
    hs_mask = 8'h00;
    if (m == MODE_STROBE_A || m == MODE_STROBE_BOTH) begin
      hs_mask[3:0] = 4'hf;
    end
    if (m == MODE_STROBE_B || m == MODE_STROBE_BOTH) begin
      hs_mask[7:4] = 4'hf;
    end
  endfunction

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  logic [ASYNC_W-1:0] sync1_reg;
  logic [ASYNC_W-1:0] sync2_reg;
  logic [15:0] s_cpu_d;
  logic [15:0] s_sys_d;
  logic [15:0] s_ide_d;
  logic [7:0] s_dreq;
  logic [2:0] s_chan;
  logic [2:0] s_addr;
  logic [7:0] s_pa;
  logic [7:0] s_pb;
  logic [7:0] s_pc;
  logic s_py;
  logic [3:0] s_pz;
  logic s_io_rd_n;
  logic s_io_wr_n;
  logic s_mem_rd_n;
  logic s_mem_wr_n;
  logic s_blk_n;
  logic s_fix_n;
  logic s_low_megabyte_flag_n;
  logic s_ide_lo_n;
  logic s_ide_hi_n;
  logic s_ack_en;

  always_ff @(posedge clk_in) begin
    sync1_reg <= {cpu_data_in, sys_data_in, ide_data_in, dma_request_in, channel_select_in,
                  addr_low_in, port_a_in, port_b_in, port_c_in, port_y_in, port_z_in,
                  io_read_n_in, io_write_n_in, mem_read_n_in, mem_write_n_in,
                  port_block_select_n_in, fixed_port_select_n_in, low_megabyte_flag_n_in,
                  drive_low_byte_enable_n_in, drive_high_byte_enable_n_in,
                  ack_demux_enable_in};
    sync2_reg <= sync1_reg;
  end

  assign {s_cpu_d, s_sys_d, s_ide_d, s_dreq, s_chan, s_addr, s_pa, s_pb, s_pc, s_py, s_pz,
          s_io_rd_n, s_io_wr_n, s_mem_rd_n, s_mem_wr_n, s_blk_n, s_fix_n, s_low_megabyte_flag_n,
          s_ide_lo_n, s_ide_hi_n, s_ack_en} = sync2_reg;

  // ==========================================================================
  // Register access strobes
  // ==========================================================================
  logic io_rd_prev_reg;
  logic io_wr_prev_reg;
  logic [7:0] wr_data_reg;
  logic [2:0] acc_addr_reg;
  logic acc_blk_reg;
  logic acc_fix_reg;
  logic rd_end;
  logic wr_end;
  logic blk_wr_end;

  // Address, select and data are held from inside the strobe, so the
  // deasserting edge still sees the values the host presented.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      io_rd_prev_reg <= 1'b0;
      io_wr_prev_reg <= 1'b0;
      wr_data_reg <= 8'h00;
      acc_addr_reg <= 3'h0;
      acc_blk_reg <= 1'b0;
      acc_fix_reg <= 1'b0;
    end else begin
      io_rd_prev_reg <= ~s_io_rd_n;
      io_wr_prev_reg <= ~s_io_wr_n;
      if (!s_io_rd_n || !s_io_wr_n) begin
        acc_addr_reg <= s_addr;
        acc_blk_reg <= ~s_blk_n;
        acc_fix_reg <= ~s_fix_n;
        wr_data_reg <= s_cpu_d[7:0];
      end
    end
  end

  assign rd_end = io_rd_prev_reg & s_io_rd_n;
  assign wr_end = io_wr_prev_reg & s_io_wr_n;
  assign blk_wr_end = wr_end & acc_blk_reg;

  // ==========================================================================
  // Mode control
  // ==========================================================================
  logic [7:0] mode_ctl_reg;
  port_mode_e mode;
  logic [1:0] strobed;
  logic [1:0] port_dir;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      mode_ctl_reg <= MODE_CONTROL_RESET;
    end else if (blk_wr_end && acc_addr_reg == SEL_MODE) begin
      mode_ctl_reg <= wr_data_reg;
    end
  end

  assign mode = port_mode_e'(mode_ctl_reg[MODE_HI_BIT:MODE_LO_BIT]);
  assign strobed[0] = (mode == MODE_STROBE_A) || (mode == MODE_STROBE_BOTH);
  assign strobed[1] = (mode == MODE_STROBE_B) || (mode == MODE_STROBE_BOTH);
  assign port_dir = {mode_ctl_reg[DIR_B_BIT], mode_ctl_reg[DIR_A_BIT]};
  assign full_strength_out = mode_ctl_reg[STRENGTH_BIT];

  // ==========================================================================
  // Port latches
  // ==========================================================================
  logic [7:0] port_a_reg;
  logic [7:0] port_b_reg;
  logic [7:0] port_c_reg;
  logic port_y_reg;
  logic [7:0] bit_free;

  assign bit_free = ~hs_mask(mode);

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      port_a_reg <= PORT_DATA_RESET;
      port_b_reg <= PORT_DATA_RESET;
      port_c_reg <= PORT_DATA_RESET;
      port_y_reg <= 1'b0;
    end else if (blk_wr_end) begin
      unique case (acc_addr_reg)
        SEL_PORT_A: port_a_reg <= wr_data_reg;
        SEL_PORT_B: port_b_reg <= wr_data_reg;
        SEL_PORT_C: port_c_reg <= wr_data_reg;
        SEL_PORT_Y: port_y_reg <= wr_data_reg[0];
        SEL_BIT_MOD: begin
          // Handshake lines of a strobed port are not open to single-bit writes.
          if (bit_free[wr_data_reg[2:0]]) begin
            port_c_reg[wr_data_reg[2:0]] <= wr_data_reg[BIT_VALUE_POS];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // Strobed handshake and two-entry input buffers
  // ==========================================================================
  logic [7:0] fifo_mem [2][BUF_DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg [2];
  logic [PTR_W-1:0] rd_ptr_reg [2];
  logic [CNT_W-1:0] count_reg [2];
  logic [1:0] stb_prev_reg;
  logic [1:0] obf_n_reg;
  logic [1:0] push;
  logic [1:0] pop;
  logic [1:0] fifo_ready;
  logic [1:0] fifo_valid;
  logic [1:0] port_wr;
  logic [1:0] port_rd_end;
  logic [7:0] pin_data [2];
  logic [7:0] head_data [2];

  assign pin_data[0] = s_pa;
  assign pin_data[1] = s_pb;
  assign port_wr[0] = blk_wr_end && acc_addr_reg == SEL_PORT_A;
  assign port_wr[1] = blk_wr_end && acc_addr_reg == SEL_PORT_B;
  assign port_rd_end[0] = rd_end && acc_blk_reg && acc_addr_reg == SEL_PORT_A;
  assign port_rd_end[1] = rd_end && acc_blk_reg && acc_addr_reg == SEL_PORT_B;

  always_comb begin
    for (int p = 0; p < 2; p++) begin
      fifo_valid[p] = count_reg[p] != '0;
      fifo_ready[p] = 32'(count_reg[p]) < BUF_DEPTH;
      head_data[p] = fifo_mem[p][rd_ptr_reg[p]];
      // A strobe that arrives while the buffer is full is ignored and its byte is lost;
      // the input-full flag only shows that the buffer holds at least one byte.
      push[p] = strobed[p] && !port_dir[p] && stb_prev_reg[p]
                && !s_pc[4*p+HS_STB] && fifo_ready[p];
      pop[p] = strobed[p] && !port_dir[p] && port_rd_end[p] && fifo_valid[p];
    end
  end

  always_ff @(posedge clk_in) begin
    for (int p = 0; p < 2; p++) begin
      if (srst_in || !strobed[p] || port_dir[p]) begin
        wr_ptr_reg[p] <= '0;
        rd_ptr_reg[p] <= '0;
        count_reg[p] <= '0;
      end else begin
        if (push[p]) begin
          fifo_mem[p][wr_ptr_reg[p]] <= pin_data[p];
          wr_ptr_reg[p] <= next_ptr(wr_ptr_reg[p]);
        end
        if (pop[p]) begin
          rd_ptr_reg[p] <= next_ptr(rd_ptr_reg[p]);
        end
        if (push[p] && !pop[p]) begin
          count_reg[p] <= count_reg[p] + 1'b1;
        end else if (pop[p] && !push[p]) begin
          count_reg[p] <= count_reg[p] - 1'b1;
        end
      end
    end
  end

  // Output-full is active low; a CPU write in the same cycle as an
  // acknowledge wins that cycle; an acknowledge still low one cycle later reports the new word as taken.
  always_ff @(posedge clk_in) begin
    for (int p = 0; p < 2; p++) begin
      if (srst_in) begin
        stb_prev_reg[p] <= 1'b1;
        obf_n_reg[p] <= 1'b1;
      end else begin
        stb_prev_reg[p] <= s_pc[4*p+HS_STB];
        if (!strobed[p] || !port_dir[p]) begin
          obf_n_reg[p] <= 1'b1;
        end else if (port_wr[p]) begin
          obf_n_reg[p] <= 1'b0;
        end else if (!s_pc[4*p+HS_ACK]) begin
          obf_n_reg[p] <= 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // Pin drive and read-back values
  // ==========================================================================
  logic [7:0] pc_drive;
  logic [7:0] pc_oe_n;
  logic [7:0] pc_read;
  logic [7:0] pa_read;
  logic [7:0] pb_read;
  logic [7:0] reg_rd_data;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pc_drive[i] = port_c_reg[i];
      pc_oe_n[i] = ~mode_ctl_reg[DIR_C_BIT];
      pc_read[i] = mode_ctl_reg[DIR_C_BIT] ? port_c_reg[i] : s_pc[i];
    end
    for (int p = 0; p < 2; p++) begin
      if (strobed[p]) begin
        pc_drive[4*p+HS_IBF] = fifo_valid[p];
        pc_drive[4*p+HS_OBF] = obf_n_reg[p];
        pc_oe_n[4*p+HS_STB] = 1'b1;
        pc_oe_n[4*p+HS_IBF] = 1'b0;
        pc_oe_n[4*p+HS_OBF] = 1'b0;
        pc_oe_n[4*p+HS_ACK] = 1'b1;
        pc_read[4*p+HS_STB] = s_pc[4*p+HS_STB];
        pc_read[4*p+HS_IBF] = fifo_valid[p];
        pc_read[4*p+HS_OBF] = obf_n_reg[p];
        pc_read[4*p+HS_ACK] = s_pc[4*p+HS_ACK];
      end
    end
    pa_read = mode_ctl_reg[DIR_A_BIT] ? port_a_reg : (strobed[0] ? head_data[0] : s_pa);
    pb_read = mode_ctl_reg[DIR_B_BIT] ? port_b_reg : (strobed[1] ? head_data[1] : s_pb);
    unique case (s_addr)
      SEL_PORT_A: reg_rd_data = pa_read;
      SEL_PORT_B: reg_rd_data = pb_read;
      SEL_PORT_C: reg_rd_data = pc_read;
      SEL_PORT_Y: reg_rd_data = {7'h00, mode_ctl_reg[DIR_Y_BIT] ? port_y_reg : s_py};
      default: reg_rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      port_a_out <= 8'h00;
      port_b_out <= 8'h00;
      port_c_out <= 8'h00;
      port_y_out <= 1'b0;
      port_a_oe_n_out <= 8'hff;
      port_b_oe_n_out <= 8'hff;
      port_c_oe_n_out <= 8'hff;
      port_y_oe_n_out <= 1'b1;
    end else begin
      port_a_out <= port_a_reg;
      port_b_out <= port_b_reg;
      port_c_out <= pc_drive;
      port_y_out <= port_y_reg;
      port_a_oe_n_out <= {8{~mode_ctl_reg[DIR_A_BIT]}};
      port_b_oe_n_out <= {8{~mode_ctl_reg[DIR_B_BIT]}};
      port_c_oe_n_out <= pc_oe_n;
      port_y_oe_n_out <= ~mode_ctl_reg[DIR_Y_BIT];
    end
  end

  // ==========================================================================
  // Data bus steering
  // ==========================================================================
  logic host_rd;
  logic host_wr;
  logic blk_rd;
  logic fix_rd;
  logic own_sel;
  logic [1:0] ide_en;

  assign host_rd = ~s_io_rd_n | ~s_mem_rd_n;
  assign host_wr = ~s_io_wr_n | ~s_mem_wr_n;
  assign own_sel = ~s_blk_n | ~s_fix_n;
  assign blk_rd = ~s_io_rd_n & ~s_blk_n;
  assign fix_rd = ~s_io_rd_n & ~s_fix_n;
  assign ide_en = {~s_ide_hi_n, ~s_ide_lo_n};

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cpu_data_out <= 16'h0000;
      cpu_data_oe_n_out <= 2'b11;
      sys_data_out <= 16'h0000;
      sys_data_oe_n_out <= 2'b11;
      ide_data_out <= 16'h0000;
      ide_data_oe_n_out <= 2'b11;
    end else begin
      cpu_data_oe_n_out <= 2'b11;
      sys_data_oe_n_out <= 2'b11;
      ide_data_oe_n_out <= 2'b11;
      cpu_data_out <= s_sys_d;
      sys_data_out <= s_cpu_d;
      ide_data_out <= s_cpu_d;
      if (blk_rd) begin
        cpu_data_out <= {8'h00, reg_rd_data};
        cpu_data_oe_n_out <= 2'b10;
      end else if (fix_rd) begin
        // The disk-change level rides on drive bit 7 and is put on both buses.
        cpu_data_out <= {8'h00, s_ide_d[7], 3'h0, s_pz};
        cpu_data_oe_n_out <= 2'b10;
        sys_data_out <= {8'h00, s_ide_d[7], 7'h00};
        sys_data_oe_n_out <= 2'b10;
      end else if (host_rd && ide_en != 2'b00) begin
        cpu_data_out <= s_ide_d;
        cpu_data_oe_n_out <= ~ide_en;
      end else if (host_rd) begin
        cpu_data_oe_n_out <= 2'b00;
      end else if (host_wr && ide_en != 2'b00) begin
        ide_data_oe_n_out <= ~ide_en;
      end else if (host_wr && !own_sel) begin
        sys_data_oe_n_out <= 2'b00;
      end
    end
  end

  // ==========================================================================
  // DMA and low-memory strobes
  // ==========================================================================
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      merged_dma_request_out <= 1'b0;
      dma_ack_n_out <= 8'hff;
      low_mem_read_n_out <= 1'b1;
      low_mem_write_n_out <= 1'b1;
    end else begin
      merged_dma_request_out <= (s_chan == DMA_NONE_CODE) ? 1'b0 : s_dreq[s_chan];
      dma_ack_n_out <= (s_ack_en && s_chan != DMA_NONE_CODE) ?
                       ~(8'h01 << s_chan) : 8'hff;
      low_mem_read_n_out <= ~(~s_low_megabyte_flag_n & ~s_mem_rd_n);
      low_mem_write_n_out <= ~(~s_low_megabyte_flag_n & ~s_mem_wr_n);
    end
  end

endmodule

// File: dv/gpio_peer_model.sv
// Peripheral side of one general-purpose port.
// Assumes oe_n low means the block owns that pin.
`timescale 1ns/100ps
module gpio_peer_model #(
  parameter int W = 8
) (
  input wire logic [W-1:0] dev_out_in,
  input wire logic [W-1:0] dev_oe_n_in,
  input wire logic [W-1:0] peer_in,
  output logic [W-1:0] pin_out
);
  // The peer always drives, so a released pin never keeps a stale level.
  always_comb begin
    for (int i = 0; i < W; i++) begin
      pin_out[i] = dev_oe_n_in[i] ? peer_in[i] : dev_out_in[i];
    end
  end
endmodule

// File: dv/isa_data_buffer_io_ports_checker.sv
// Checker: port-level timing of the data-buffer block.
// Assumes the three-edge pin-to-pin latency of the input synchronisers.
`timescale 1ns/100ps
module isa_data_buffer_io_ports_checker
  import gpio_buffer_pkg::*;
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic [2:0] channel_select_in,
  input wire logic [7:0] dma_request_in,
  input wire logic ack_demux_enable_in,
  input wire logic merged_dma_request_out,
  input wire logic [7:0] dma_ack_n_out,
  input wire logic low_megabyte_flag_n_in,
  input wire logic mem_read_n_in,
  input wire logic mem_write_n_in,
  input wire logic low_mem_read_n_out,
  input wire logic low_mem_write_n_out,
  input wire logic [1:0] cpu_data_oe_n_out,
  input wire logic [15:0] cpu_data_out,
  input wire logic [7:0] port_a_oe_n_out,
  input wire logic full_strength_out,
  input wire logic port_block_select_n_in,
  input wire logic fixed_port_select_n_in,
  input wire logic io_read_n_in,
  input wire logic [2:0] addr_low_in,
  input wire logic [3:0] port_z_in
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  // =====================================================================
  // Settling counter
  // =====================================================================
  // The synchronisers carry no reset, so relations start once they refill.
  logic [2:0] settle_reg;
  always_ff @(posedge clk_in) begin
    if (srst_in) settle_reg <= 3'h0;
    else if (settle_reg != 3'h7) settle_reg <= settle_reg + 3'h1;
  end
  wire logic settled = settle_reg > 3'h4;
  chk_req_mux: assert property (settled |-> merged_dma_request_out ==
    ($past(channel_select_in, 3) == DMA_NONE_CODE ? 1'b0 :
    $past(dma_request_in[channel_select_in], 3))) else $error("merged request wrong");
  chk_ack_demux: assert property (settled |-> dma_ack_n_out ==
    (($past(ack_demux_enable_in, 3) && $past(channel_select_in, 3) != DMA_NONE_CODE) ?
    ~(8'h01 << $past(channel_select_in, 3)) : 8'hff)) else $error("acknowledge wrong");
  chk_low_mem_read: assert property (settled |-> low_mem_read_n_out ==
    $past(low_megabyte_flag_n_in | mem_read_n_in, 3)) else $error("low read strobe wrong");
  chk_low_mem_write: assert property (settled |-> low_mem_write_n_out ==
    $past(low_megabyte_flag_n_in | mem_write_n_in, 3)) else $error("low write strobe wrong");
  chk_reset_outputs: assert property ($fell(srst_in) |-> cpu_data_oe_n_out == 2'b11 &&
    port_a_oe_n_out == 8'hff && !full_strength_out) else $error("reset outputs wrong");
  chk_block_read_oe: assert property (settled &&
    $past(!port_block_select_n_in && !io_read_n_in, 3) |-> cpu_data_oe_n_out == 2'b10)
    else $error("block read enables wrong");
  chk_fixed_read: assert property (settled && $past(port_block_select_n_in &&
    !fixed_port_select_n_in && !io_read_n_in, 3) |-> cpu_data_out[3:0] == $past(port_z_in, 3))
    else $error("fixed port data wrong");
  chk_strength_cause: assert property (settled && $changed(full_strength_out) |->
    $past(!port_block_select_n_in && addr_low_in == SEL_MODE, 3))
    else $error("strength changed without mode write");
endmodule
bind isa_data_buffer_io_ports isa_data_buffer_io_ports_checker u_chk (.clk_in(clk_in),
  .srst_in(srst_in), .channel_select_in(channel_select_in), .dma_request_in(dma_request_in),
  .ack_demux_enable_in(ack_demux_enable_in), .merged_dma_request_out(merged_dma_request_out),
  .dma_ack_n_out(dma_ack_n_out), .low_megabyte_flag_n_in(low_megabyte_flag_n_in),
  .mem_read_n_in(mem_read_n_in), .mem_write_n_in(mem_write_n_in),
  .low_mem_read_n_out(low_mem_read_n_out), .low_mem_write_n_out(low_mem_write_n_out),
  .cpu_data_oe_n_out(cpu_data_oe_n_out), .cpu_data_out(cpu_data_out),
  .port_a_oe_n_out(port_a_oe_n_out), .full_strength_out(full_strength_out),
  .port_block_select_n_in(port_block_select_n_in), .io_read_n_in(io_read_n_in),
  .fixed_port_select_n_in(fixed_port_select_n_in), .addr_low_in(addr_low_in),
  .port_z_in(port_z_in));

// File: dv/tb.sv
// Testbench: drives host strobes and peripheral pins of the port block.
// Assumes the three-edge latency, so every check waits at least four cycles.
`timescale 1ns/100ps
module tb;
  import gpio_buffer_pkg::*;
  `define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin errors++; \
    $display("BAD %s expected %h seen %h", n, e, s); end end
  logic clk_in = 0;
  logic srst_in = 1;
  logic [15:0] cpu_d, sys_d, ide_d, cpu_q, sys_q, ide_q;
  logic [1:0] cpu_oe, sys_oe, ide_oe;
  logic den_l_n, den_h_n, ior_n, iow_n, mr_n, mw_n, blk_n, fix_n, lomeg_n, ack_en;
  logic req_q, smr_n, smw_n, full_q, py_q, py_oe, peer_y, pin_y;
  logic [2:0] addr, chan;
  logic [7:0] drq, dack_n, pa_q, pa_oe, pb_q, pb_oe, pc_q, pc_oe;
  logic [7:0] peer_a, peer_b, peer_c, pin_a, pin_b, pin_c;
  logic [3:0] pz;
  logic [2:0] sel_tab [3] = '{SEL_PORT_C, SEL_PORT_A, SEL_PORT_B};
  int errors = 0;
  int samples_checked = 0;
  int tick_cnt = 0;
  initial forever #12.5 clk_in = ~clk_in;
  isa_data_buffer_io_ports #(.BUF_DEPTH(2)) dut (.clk_in(clk_in), .srst_in(srst_in),
    .cpu_data_in(cpu_d), .cpu_data_out(cpu_q), .cpu_data_oe_n_out(cpu_oe),
    .sys_data_in(sys_d), .sys_data_out(sys_q), .sys_data_oe_n_out(sys_oe),
    .ide_data_in(ide_d), .ide_data_out(ide_q), .ide_data_oe_n_out(ide_oe),
    .drive_low_byte_enable_n_in(den_l_n), .drive_high_byte_enable_n_in(den_h_n),
    .io_read_n_in(ior_n), .io_write_n_in(iow_n), .mem_read_n_in(mr_n),
    .mem_write_n_in(mw_n), .addr_low_in(addr), .port_block_select_n_in(blk_n),
    .fixed_port_select_n_in(fix_n), .dma_request_in(drq), .channel_select_in(chan),
    .ack_demux_enable_in(ack_en), .merged_dma_request_out(req_q), .dma_ack_n_out(dack_n),
    .low_megabyte_flag_n_in(lomeg_n), .low_mem_read_n_out(smr_n),
    .low_mem_write_n_out(smw_n), .port_a_in(pin_a), .port_a_out(pa_q),
    .port_a_oe_n_out(pa_oe), .port_b_in(pin_b), .port_b_out(pb_q), .port_b_oe_n_out(pb_oe),
    .port_c_in(pin_c), .port_c_out(pc_q), .port_c_oe_n_out(pc_oe), .port_y_in(pin_y),
    .port_y_out(py_q), .port_y_oe_n_out(py_oe), .port_z_in(pz), .full_strength_out(full_q));
  gpio_peer_model #(.W(8)) peer_pa (.dev_out_in(pa_q), .dev_oe_n_in(pa_oe),
    .peer_in(peer_a), .pin_out(pin_a));
  gpio_peer_model #(.W(8)) peer_pb (.dev_out_in(pb_q), .dev_oe_n_in(pb_oe),
    .peer_in(peer_b), .pin_out(pin_b));
  gpio_peer_model #(.W(8)) peer_pc (.dev_out_in(pc_q), .dev_oe_n_in(pc_oe),
    .peer_in(peer_c), .pin_out(pin_c));
  gpio_peer_model #(.W(1)) peer_py (.dev_out_in(py_q), .dev_oe_n_in(py_oe),
    .peer_in(peer_y), .pin_out(pin_y));
  function automatic logic f_req(logic [7:0] r, logic [2:0] c);
    return (c == DMA_NONE_CODE) ? 1'b0 : r[c];
  endfunction
  function automatic logic [7:0] f_ack(logic en, logic [2:0] c);
    return (en && c != DMA_NONE_CODE) ? ~(8'h01 << c) : 8'hff;
  endfunction
  task automatic idle(int n);
    repeat (n) @(negedge clk_in);
  endtask
  // Strobes stay long on both sides because every pin crosses two flops.
  task automatic wr(logic [2:0] a, logic [7:0] d);
    addr = a;
    cpu_d = {8'h00, d};
    blk_n = 0;
    idle(1);
    iow_n = 0;
    idle(5);
    iow_n = 1;
    idle(4);
    blk_n = 1;
    idle(4);
  endtask
  task automatic rd(logic fx, logic [2:0] a, output logic [7:0] q);
    addr = a;
    blk_n = fx;
    fix_n = !fx;
    idle(1);
    ior_n = 0;
    idle(5);
    q = cpu_q[7:0];
    ior_n = 1;
    idle(4);
    blk_n = 1;
    fix_n = 1;
    idle(4);
  endtask
  task automatic rchk(string n, logic [2:0] a, logic [7:0] e);
    logic [7:0] q;
    rd(0, a, q);
    `CHK(n, e, q)
  endtask
  task automatic print_verdict();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk_in) begin
    tick_cnt++;
    if (tick_cnt == 20000) begin
      errors++;
      print_verdict();
    end
  end
  initial begin
    logic [7:0] v, d, c_exp;
    {den_l_n, den_h_n, ior_n, iow_n, mr_n, mw_n, blk_n, fix_n, lomeg_n} = '1;
    {ack_en, addr, chan, drq, pz, peer_y} = '0;
    {cpu_d, sys_d, ide_d} = '0;
    {peer_a, peer_b, peer_c} = '0;
    void'($urandom(32'hc8b7a67a));
    idle(12);
    srst_in = 0;
    idle(4);
    `CHK("oe_a", 8'hff, pa_oe)
    `CHK("strength", 1'b0, full_q)
    wr(SEL_MODE, 8'h0f);
    for (int i = 0; i < 3; i++) begin
      d = 8'($urandom);
      wr(sel_tab[i], d);
      v = (i == 0) ? pc_q : (i == 1) ? pa_q : pb_q;
      `CHK("pin", d, v)
      v = (i == 0) ? pc_oe : (i == 1) ? pa_oe : pb_oe;
      `CHK("oe", 8'h00, v)
      rchk("port", sel_tab[i], d);
      if (i == 0) c_exp = d;
    end
    wr(SEL_PORT_Y, 8'h01);
    `CHK("y", 1'b1, py_q)
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom);
      wr(SEL_BIT_MOD, {4'h0, v[0], 3'(i)});
      c_exp[i] = v[0];
      `CHK("bitmod", c_exp, pc_q)
    end
    wr(SEL_MODE, 8'h2f);
    `CHK("strength", 1'b1, full_q)
    rchk("mode", SEL_MODE, 8'h00);
    d = pa_q;
    wr(3'h6, ~d);
    rchk("resv", SEL_PORT_A, d);
    wr(SEL_MODE, 8'h00);
    for (int r = 0; r < 2; r++) begin
      {peer_a, peer_b, peer_c} = 24'($urandom);
      rchk("live_c", SEL_PORT_C, peer_c);
      rchk("live_a", SEL_PORT_A, peer_a);
      rchk("live_b", SEL_PORT_B, peer_b);
    end
    pz = 4'($urandom);
    ide_d = 16'($urandom);
    rd(1, 3'h0, v);
    `CHK("fixed", pz, v[3:0])
    `CHK("disk_chg", ide_d[7], v[7])
    for (int c = 0; c < 8; c++) begin
      chan = 3'(c);
      drq = 8'($urandom) | 8'h10;
      ack_en = 1'($urandom);
      idle(4);
      `CHK("req", f_req(drq, chan), req_q)
      `CHK("ack", f_ack(ack_en, chan), dack_n)
    end
    for (int k = 0; k < 8; k++) begin
      {lomeg_n, mr_n, mw_n} = 3'(k);
      idle(4);
      `CHK("smr", lomeg_n | mr_n, smr_n)
      `CHK("smw", lomeg_n | mw_n, smw_n)
    end
    ide_d = 16'($urandom);
    den_l_n = 0;
    ior_n = 0;
    idle(5);
    `CHK("ide_oe", 2'b10, cpu_oe)
    `CHK("ide_rd", ide_d[7:0], cpu_q[7:0])
    ior_n = 1;
    den_l_n = 1;
    idle(4);
    cpu_d = 16'($urandom);
    iow_n = 0;
    idle(5);
    `CHK("sys_wr", cpu_d, sys_q)
    `CHK("sys_oe", 2'b00, sys_oe)
    iow_n = 1;
    idle(5);
    for (int m = 1; m < 4; m++) begin
      wr(SEL_MODE, {2'(m), 6'h00});
      peer_c = 8'h11;
      v = 8'($urandom);
      if (m == 1) peer_a = v;
      else peer_b = v;
      idle(4);
      peer_c = (m == 1) ? 8'h10 : 8'h01;
      idle(4);
      peer_c = 8'h11;
      idle(4);
      {peer_a, peer_b} = ~{v, v};
      rd(0, SEL_PORT_C, d);
      `CHK("ibf", 1'b1, d[m[1] ? 5 : 1])
      rchk("strobed", (m == 1) ? SEL_PORT_A : SEL_PORT_B, v);
      rd(0, SEL_PORT_C, d);
      `CHK("ibf_clr", 1'b0, d[m[1] ? 5 : 1])
    end
    peer_c = 8'h19;
    wr(SEL_MODE, 8'h41);
    wr(SEL_PORT_A, v);
    `CHK("obf", 1'b0, pc_q[2])
    peer_c = 8'h11;
    idle(4);
    `CHK("obf_ack", 1'b1, pc_q[2])
    print_verdict();
  end
endmodule
